//--- tb/smpc_core_model.sv
// behavioural processor core issuing stop and halt
`timescale 1ns/100ps
module smpc_core_model
(
  input wire logic clk,
  input wire logic do_stop,
  input wire logic do_halt,
  input wire logic use_ext,
  output smpc_pkg::smpc_core_req_type core_req
);
  // one decode cycle lag; external clock only when commanded
  always @(negedge clk)
    core_req <= '{do_stop, do_halt, use_ext};
endmodule : smpc_core_model

//--- tb/stop_mode_power_control_test.sv
// self-checking bench for the stop mode power controller
`timescale 1ns/100ps
module stop_mode_power_control_test;
  logic clk, reset_n, do_stop, do_halt, use_ext, wen, ven, rec, wake;
  logic in_stop, in_halt, misuse;
  smpc_pkg::smpc_core_req_type core_req;
  smpc_pkg::smpc_sleep_cfg_type cfg;
  smpc_pkg::smpc_gate_type gate;
  int fails, compares;

  smpc_power_ctrl dut_u
  (
    .clk(clk), .reset_n(reset_n), .core_req(core_req), .sleep_cfg(cfg),
    .wdt_run_en(wen), .vbo_run_en(ven), .stop_recovery(rec),
    .halt_wake(wake), .gate(gate), .in_stop(in_stop), .in_halt(in_halt),
    .stop_misuse(misuse)
  );
  smpc_core_model core_u
  (
    .clk(clk), .do_stop(do_stop), .do_halt(do_halt), .use_ext(use_ext),
    .core_req(core_req)
  );

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [13:0] snap();
    return {2'h0, in_stop, in_halt, misuse, gate.osc_run, gate.xin_oe,
      gate.xout_oe, gate.sysclk_en, gate.core_run, gate.pc_inc_en,
      gate.periph_run, gate.wdt_run, gate.vbo_run};
  endfunction : snap

  // one-cycle instruction pulse, answer seen two cycles later
  task automatic issue(input logic s);
    do_stop <= s;
    do_halt <= !s;
    @(negedge clk);
    do_stop <= 1'h0;
    do_halt <= 1'h0;
    repeat (2) @(negedge clk);
  endtask : issue

  // c = run enables then stop enables of watchdog and brown-out
  task automatic t_stop(input logic [3:0] c, input logic m);
    logic [13:0] stop_exp;
    stop_exp = {4'h2, m, 7'h30, c[3] & c[1], c[2] & c[0]};
    {wen, ven, cfg} = c;
    issue(1'h1);
    chk(snap(), stop_exp);
    chk({12'h000, gate.xin_drive, gate.xout_drive}, {12'h000,
      smpc_pkg::XIN_STOP_LEVEL, smpc_pkg::XOUT_STOP_LEVEL});
    // a halt wake must not end stop
    wake <= 1'h1;
    repeat (3) @(negedge clk);
    wake <= 1'h0;
    chk(snap(), stop_exp);
    rec <= 1'h1;
    @(negedge clk);
    rec <= 1'h0;
    chk(snap(), {4'h0, m, 7'h4F, c[3], c[2]});
  endtask : t_stop

  task automatic t_halt();
    issue(1'h0);
    chk(snap(), {5'h02, 7'h49, 2'h3});
    wake <= 1'h1;
    @(negedge clk);
    wake <= 1'h0;
    chk(snap(), {5'h00, 7'h4F, 2'h3});
  endtask : t_halt

  // a stop is refused while halted; recovery also ends halt
  task automatic t_halt_stop();
    issue(1'h0);
    issue(1'h1);
    chk(snap(), {5'h02, 7'h49, 2'h3});
    rec <= 1'h1;
    @(negedge clk);
    rec <= 1'h0;
    chk(snap(), {5'h00, 7'h4F, 2'h3});
  endtask : t_halt_stop

  initial
  begin
    #20000;
    fails++;
    summarize();
  end

  initial
  begin
    {reset_n, do_stop, do_halt, use_ext, wen, ven, rec, wake} = 8'h00;
    cfg = '0;
    fails = 0;
    compares = 0;
    repeat (6) @(negedge clk);
    reset_n = 1'h1;
    @(negedge clk);
    chk(snap(), {5'h00, 7'h4F, 2'h0});
    for (int i = 0; i < 16; i++)
      t_stop(i[3:0], 1'h0);
    t_halt();
    t_halt_stop();
    use_ext <= 1'h1;
    t_stop(4'hF, 1'h1);
    summarize();
  end
endmodule : stop_mode_power_control_test

//--- verilog/smpc_pkg.sv
// package for the stop mode power controller
package smpc_pkg;
  // power state codes, one-hot
  localparam logic [2:0] ST_RUN = 3'h1;
  localparam logic [2:0] ST_HALT = 3'h2;
  localparam logic [2:0] ST_STOP = 3'h4;
  localparam logic [2:0] ST_RESET = 3'h1;
  localparam logic XIN_STOP_LEVEL = 1'h1;
  localparam logic XOUT_STOP_LEVEL = 1'h0;

  typedef enum logic [2:0]
  {
    SMPC_RUN = ST_RUN,
    SMPC_HALT = ST_HALT,
    SMPC_STOP = ST_STOP
  } smpc_state_type;

  // request group coming from the processor core
  typedef struct packed
  {
    logic stop_exec;
    logic halt_exec;
    logic ext_clk_sel;
  } smpc_core_req_type;

  // enables of the blocks that may run through stop
  typedef struct packed
  {
    logic wdt_stop_en;
    logic vbo_stop_en;
  } smpc_sleep_cfg_type;

  // gating outputs toward oscillator, core and peripherals
  typedef struct packed
  {
    logic osc_run;
    logic xin_drive;
    logic xin_oe;
    logic xout_drive;
    logic xout_oe;
    logic sysclk_en;
    logic core_run;
    logic pc_inc_en;
    logic wdt_run;
    logic vbo_run;
    logic periph_run;
  } smpc_gate_type;
endpackage : smpc_pkg

//--- verilog/smpc_power_ctrl.sv
// stop mode power control state machine and gating
// Functional notes
// [RQ1] a stop instruction from the core puts the device into stop mode. The code enters stop only from run; a stop in halt is ignored.
// [RQ2] in stop the crystal oscillator halts, xin is driven high, xout low.
// [RQ3] in stop the system clock enable is held off.
// [RQ4] in stop the core halts and the program counter does not advance.
// [RQ5] watchdog and its rc oscillator run in stop only when enabled.
// [RQ6] brown-out monitor runs in stop only when its option bit enables it.
// [RQ7] all other peripherals are idle in stop.
// [RQ8] stop is left only through the stop mode recovery input.
// [RQ9] software must not use stop while running from an external clock. The code still enters stop and sets the sticky stop_misuse flag.
// [RQ10] software should disable watchdog and brown-out before stop.
// [RQ11] two saving states exist: deep stop and lighter halt.
// [RQ12] register and configuration contents are kept across stop.
`timescale 1ns/100ps
module smpc_power_ctrl
(
  input wire logic clk,
  input wire logic reset_n,
  input wire smpc_pkg::smpc_core_req_type core_req,
  input wire smpc_pkg::smpc_sleep_cfg_type sleep_cfg,
  input wire logic wdt_run_en,
  input wire logic vbo_run_en,
  input wire logic stop_recovery,
  input wire logic halt_wake,
  output smpc_pkg::smpc_gate_type gate,
  output logic in_stop,
  output logic in_halt,
  output logic stop_misuse
);
  smpc_pkg::smpc_state_type state_r;
  smpc_pkg::smpc_state_type state_nxt;
  smpc_pkg::smpc_gate_type gate_r;
  smpc_pkg::smpc_gate_type gate_nxt;
  logic stop_misuse_r;
  logic stop_misuse_nxt;
  // state flags decoded ahead so they leave straight from flops
  logic in_stop_r;
  logic in_halt_r;
  wire stop_go;
  wire halt_go;
  wire nxt_stop;
  wire nxt_halt;
  wire nxt_run;

  // stop wins over halt if both arrive together
  assign stop_go = core_req.stop_exec; // [RQ1]
  assign halt_go = core_req.halt_exec & ~core_req.stop_exec; // [RQ11]
  assign nxt_stop = state_nxt == smpc_pkg::SMPC_STOP;
  assign nxt_halt = state_nxt == smpc_pkg::SMPC_HALT;
  assign nxt_run = state_nxt == smpc_pkg::SMPC_RUN;
  // external clock use is flagged, not blocked: the core owns that choice
  assign stop_misuse_nxt = stop_misuse_r |
    (stop_go & core_req.ext_clk_sel & (state_r == smpc_pkg::SMPC_RUN));

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      smpc_pkg::SMPC_RUN:
      begin
        if (stop_go)
          state_nxt = smpc_pkg::SMPC_STOP; // [RQ1]
        else if (halt_go)
          state_nxt = smpc_pkg::SMPC_HALT; // [RQ11]
      end
      smpc_pkg::SMPC_HALT:
      begin
        if (halt_wake | stop_recovery)
          state_nxt = smpc_pkg::SMPC_RUN;
      end
      smpc_pkg::SMPC_STOP:
      begin
        // only recovery leaves stop; halt wake sources are ignored
        if (stop_recovery)
          state_nxt = smpc_pkg::SMPC_RUN; // [RQ8]
      end
    endcase
  end

  always_comb
  begin
    gate_nxt.osc_run = ~nxt_stop; // [RQ2]
    gate_nxt.xin_drive = nxt_stop ? smpc_pkg::XIN_STOP_LEVEL : 1'h0; // [RQ2]
    gate_nxt.xin_oe = nxt_stop; // [RQ2]
    gate_nxt.xout_drive = smpc_pkg::XOUT_STOP_LEVEL; // [RQ2]
    gate_nxt.xout_oe = nxt_stop; // [RQ2]
    gate_nxt.sysclk_en = ~nxt_stop; // [RQ3]
    gate_nxt.core_run = nxt_run; // [RQ4]
    gate_nxt.pc_inc_en = nxt_run; // [RQ4]
    gate_nxt.wdt_run = wdt_run_en &
      (~nxt_stop | sleep_cfg.wdt_stop_en); // [RQ5]
    gate_nxt.vbo_run = vbo_run_en &
      (~nxt_stop | sleep_cfg.vbo_stop_en); // [RQ6]
    // halt keeps peripherals alive; only stop idles them
    gate_nxt.periph_run = ~nxt_stop; // [RQ7]
  end

  // no reset of contents here: gating only, state elsewhere is kept
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= smpc_pkg::smpc_state_type'(smpc_pkg::ST_RESET);
      gate_r <= '{osc_run: 1'h1, xin_drive: 1'h0, xin_oe: 1'h0,
        xout_drive: 1'h0, xout_oe: 1'h0, sysclk_en: 1'h1, core_run: 1'h1,
        pc_inc_en: 1'h1, wdt_run: 1'h0, vbo_run: 1'h0, periph_run: 1'h1};
      stop_misuse_r <= 1'h0;
      in_stop_r <= 1'h0;
      in_halt_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      gate_r <= gate_nxt; // [RQ12]
      stop_misuse_r <= stop_misuse_nxt; // [RQ9]
      in_stop_r <= nxt_stop; // [RQ1]
      in_halt_r <= nxt_halt; // [RQ11]
    end
  end

  assign gate = gate_r;
  assign in_stop = in_stop_r;
  assign in_halt = in_halt_r;
  assign stop_misuse = stop_misuse_r;

  property p_stop_entry;
    @(posedge clk) disable iff (!reset_n)
      (state_r == smpc_pkg::SMPC_RUN) && core_req.stop_exec
      |=> in_stop && !gate.osc_run;
  endproperty
  a_stop_entry: assert property (p_stop_entry) // [RQ1]
    else $error("stop instruction did not enter stop");

  property p_pads;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> gate.xin_oe && gate.xin_drive && gate.xout_oe
        && !gate.xout_drive;
  endproperty
  a_pads: assert property (p_pads) // [RQ2]
    else $error("oscillator pads wrong in stop");

  property p_clk_off;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> !gate.sysclk_en;
  endproperty
  a_clk_off: assert property (p_clk_off) // [RQ3]
    else $error("system clock running in stop");

  property p_core_off;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> !gate.core_run && !gate.pc_inc_en;
  endproperty
  a_core_off: assert property (p_core_off) // [RQ4]
    else $error("core running in stop");

  property p_wdt;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> gate.wdt_run ==
        ($past(wdt_run_en) && $past(sleep_cfg.wdt_stop_en));
  endproperty
  a_wdt: assert property (p_wdt) // [RQ5]
    else $error("watchdog running in stop when not enabled");

  property p_vbo;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> gate.vbo_run ==
        ($past(vbo_run_en) && $past(sleep_cfg.vbo_stop_en));
  endproperty
  a_vbo: assert property (p_vbo) // [RQ6]
    else $error("brown-out running in stop when not enabled");

  property p_periph;
    @(posedge clk) disable iff (!reset_n)
      in_stop |-> !gate.periph_run;
  endproperty
  a_periph: assert property (p_periph) // [RQ7]
    else $error("peripherals not idle in stop");

  property p_exit;
    @(posedge clk) disable iff (!reset_n)
      in_stop && !stop_recovery |=> in_stop;
  endproperty
  a_exit: assert property (p_exit) // [RQ8]
    else $error("left stop without recovery");

  property p_recover;
    @(posedge clk) disable iff (!reset_n)
      in_stop && stop_recovery |=> !in_stop && gate.osc_run && gate.core_run;
  endproperty
  a_recover: assert property (p_recover) // [RQ8]
    else $error("recovery did not restart");

  property p_halt;
    @(posedge clk) disable iff (!reset_n)
      in_halt |-> gate.sysclk_en && !gate.core_run && gate.periph_run;
  endproperty
  a_halt: assert property (p_halt) // [RQ11]
    else $error("halt gating wrong");

  property p_run_pads;
    @(posedge clk) disable iff (!reset_n)
      !in_stop |-> gate.osc_run && gate.sysclk_en && !gate.xin_oe
        && !gate.xout_oe;
  endproperty
  a_run_pads: assert property (p_run_pads) // [RQ8]
    else $error("oscillator or clock off outside stop");

  property p_halt_hold;
    @(posedge clk) disable iff (!reset_n)
      in_halt && !halt_wake && !stop_recovery |=> in_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) // [RQ11]
    else $error("left halt without a wake event");

  property p_misuse_set;
    @(posedge clk) disable iff (!reset_n)
      (state_r == smpc_pkg::SMPC_RUN) && core_req.stop_exec
        && core_req.ext_clk_sel |=> stop_misuse && in_stop;
  endproperty
  a_misuse_set: assert property (p_misuse_set) // [RQ9]
    else $error("stop on external clock not flagged");

  property p_misuse_hold;
    @(posedge clk) disable iff (!reset_n)
      stop_misuse |=> stop_misuse;
  endproperty
  a_misuse_hold: assert property (p_misuse_hold) // [RQ9]
    else $error("misuse flag cleared without reset");

  c_stop: cover property (@(posedge clk) disable iff (!reset_n)
    !in_stop ##1 in_stop ##[1:20] !in_stop);
  c_halt: cover property (@(posedge clk) disable iff (!reset_n)
    !in_halt ##1 in_halt ##[1:20] !in_halt);
  c_wdt_stop: cover property (@(posedge clk) disable iff (!reset_n)
    in_stop && gate.wdt_run);
  c_misuse: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(stop_misuse));
  c_halt_refuse: cover property (@(posedge clk) disable iff (!reset_n)
    in_halt && core_req.stop_exec);
endmodule : smpc_power_ctrl
